// [rtl/ostc_pkg.sv]
// Purpose: constants and types for the oscillator startup timeout control block
// Assumes: one 250 MHz clock, APB register access, 32-bit data
// Notes: register offsets are byte addresses
// Notes on behaviour
// - select field 3:2 picks 1, 16, 64 or 256 settling counter expirations
// - ready-low output falls only after settling and the selected expirations
// - delay roughly 2.3, 37, 147 or 589 us, scaling with crystal
// - settled flag asserts in the same cycle as ready-low falls
// - keep-on bit 0 holds oscillator running in sleep; resets to 0
package ostc_pkg;

  localparam logic [7:0]  CfgOffset     = 8'h18;
  localparam logic [7:0]  IrqStatOffset = 8'h40;
  localparam logic [7:0]  IrqMaskOffset = 8'h44;
  localparam logic [7:0]  StatusOffset  = 8'h48;
  localparam logic [7:0]  CfgReset      = 8'h04;
  localparam int          SelLsb        = 2;
  localparam int          KeepOnBit     = 0;
  localparam int          Bit1          = 1;
  localparam logic [7:0]  CfgWriteMask  = 8'h3f;
  // one expiry of the settling counter, about 2.3 us at this clock
  localparam real         ExpireTimeNs  = 2300.0;
  localparam real         ClkPeriodNs   = 4.0;
  localparam logic [9:0]  ExpireCycles  = 10'($rtoi(ExpireTimeNs / ClkPeriodNs));
  localparam logic [8:0]  Expire0       = 9'h001;
  localparam logic [8:0]  Expire1       = 9'h010;
  localparam logic [8:0]  Expire2       = 9'h040;
  localparam logic [8:0]  Expire3       = 9'h100;

  typedef enum {OstcOff, OstcSettle, OstcReady} ostc_phase_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [31:0] prdata;
  } ostc_regs_t;

endpackage : ostc_pkg

// [rtl/ostc_expire_timer.sv]
// Purpose: settling counter counting expirations of a fixed interval
// Assumes: start pulse restarts, clear stops
// Notes: done is a level held until clear or restart
module ostc_expire_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic       clear,
  input  wire logic [8:0] target,
  output logic            done
);

  typedef struct packed {
    logic       run;
    logic       done;
    logic [9:0] tick;
    logic [8:0] expCnt;
  } ostc_timer_t;

  ostc_timer_t s_q;
  ostc_timer_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d = '0;
    end else if (start) begin
      s_d = '0;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.tick == ostc_pkg::ExpireCycles - 10'h001) begin
        s_d.tick = 10'h000;
        s_d.expCnt = s_q.expCnt + 9'h001;
        if (s_q.expCnt + 9'h001 == target) begin
          s_d.run = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.tick = s_q.tick + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule : ostc_expire_timer

// [rtl/ostc_ctrl.sv]
// Purpose: startup timeout and keep-on control of the crystal oscillator
// Assumes: oscRequest and sleep level come from the radio state logic
// Notes: oscStart pulse marks each oscillator start
//
// Decided for this implementation: the APB register port.
module ostc_ctrl (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        oscRequest,
  input  wire logic        sleepMode,
  output logic             oscEnable,
  output logic             chipReadyLow,
  output logic             oscSettledFlag,
  output logic [7:0]       cfgOut,
  output logic             irq
);

  typedef struct packed {
    ostc_pkg::ostc_regs_t regs;
    logic                 oscOn;
    logic                 ready;
  } ostc_state_t;

  ostc_state_t s_q;
  ostc_state_t s_d;
  logic        timerDone;
  logic        oscStart;
  logic        wantOsc;
  logic [8:0]  target;
  logic        access;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (s_q.regs.cfg[ostc_pkg::SelLsb +: 2])
      2'h0:    target = ostc_pkg::Expire0;
      2'h1:    target = ostc_pkg::Expire1;
      2'h2:    target = ostc_pkg::Expire2;
      2'h3:    target = ostc_pkg::Expire3;
      default: target = ostc_pkg::Expire0;
    endcase
  end

  // sleep gates the oscillator unless the keep-on bit holds it
  assign wantOsc  = sleepMode ? s_q.regs.cfg[ostc_pkg::KeepOnBit] : oscRequest;
  assign oscStart = wantOsc && !s_q.oscOn;
  assign access   = psel && penable;

  ostc_expire_timer u_timer (
    .clk    (clk),
    .nrst   (nrst),
    .start  (oscStart),
    .clear  (!wantOsc),
    .target (target),
    .done   (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.oscOn = wantOsc;
    s_d.ready = wantOsc && timerDone && s_q.oscOn;
    // events: bit0 ready rise, bit1 ready lost; set wins over read clear
    if (access && !pwrite && paddr == ostc_pkg::IrqStatOffset) begin
      s_d.regs.irqStat = 2'h0;
    end
    if (s_d.ready && !s_q.ready) begin
      s_d.regs.irqStat[0] = 1'b1;
    end
    if (!s_d.ready && s_q.ready) begin
      s_d.regs.irqStat[1] = 1'b1;
    end
    if (access && pwrite) begin
      case (paddr)
        ostc_pkg::CfgOffset:     s_d.regs.cfg = pwdata[7:0] & ostc_pkg::CfgWriteMask;
        ostc_pkg::IrqMaskOffset: s_d.regs.irqMask = pwdata[1:0];
        default:                 s_d.regs.cfg = s_q.regs.cfg;
      endcase
    end
    // status read shows events of the setup cycle too, else the access clear would drop them
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ostc_pkg::CfgOffset:     s_d.regs.prdata = {24'h000000, s_q.regs.cfg};
        ostc_pkg::IrqStatOffset: s_d.regs.prdata = {30'h0, s_d.regs.irqStat};
        ostc_pkg::IrqMaskOffset: s_d.regs.prdata = {30'h0, s_q.regs.irqMask};
        ostc_pkg::StatusOffset:  s_d.regs.prdata = {30'h0, s_q.oscOn, s_q.ready};
        default:                 s_d.regs.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.regs.cfg     <= ostc_pkg::CfgReset;
      s_q.regs.irqStat <= 2'h0;
      s_q.regs.irqMask <= 2'h0;
      s_q.regs.prdata  <= 32'h00000000;
      s_q.oscOn        <= 1'b0;
      s_q.ready        <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign pready         = 1'b1;
  // unmapped addresses answer with an error, reads return zero
  assign pslverr        = access && !(paddr == ostc_pkg::CfgOffset || paddr == ostc_pkg::IrqStatOffset ||
                          paddr == ostc_pkg::IrqMaskOffset || (paddr == ostc_pkg::StatusOffset && !pwrite));
  assign prdata         = s_q.regs.prdata;
  assign oscEnable      = s_q.oscOn;
  assign chipReadyLow   = !s_q.ready;
  assign oscSettledFlag = s_q.ready;
  assign cfgOut         = s_q.regs.cfg;
  assign irq            = |(s_q.regs.irqStat & s_q.regs.irqMask);

endmodule : ostc_ctrl

// [test/ostc_chk.sv]
// Purpose: port assertions for ostc_ctrl
// Assumes: one clock, async active-low reset
// Notes: cnt restarts on every oscillator start
module ostc_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       sleepMode,
  input wire logic       oscEnable,
  input wire logic       chipReadyLow,
  input wire logic       oscSettledFlag,
  input wire logic [7:0] cfgOut
);
  int cnt;
  int need;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt <= 0;
    else cnt <= oscEnable ? cnt + 1 : 0;
  end
  // select code 3 checked against the code 2 count of 64 expirations
  always_comb need = 575 * (cfgOut[3:2] == 2'h0 ? 1 : cfgOut[3:2] == 2'h1 ? 16 : 64);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////
  a_flag_pair: assert property (oscSettledFlag == !chipReadyLow)
    else $error("settled flag and ready differ");
  a_ready_osc: assert property (!chipReadyLow |-> $past(oscEnable))
    else $error("ready without oscillator");
  a_ready_wait: assert property ($fell(chipReadyLow) |-> cnt >= need - 1)
    else $error("ready too early");
  a_ready_late: assert property ($rose(oscEnable) && cfgOut[3:2] == 2'h0
    |-> ##[1:590] (!chipReadyLow || !oscEnable)) else $error("ready too late");
  a_ready_drop: assert property (!oscEnable ##1 !oscEnable |-> chipReadyLow)
    else $error("ready held while oscillator off");
  a_keep_on: assert property (sleepMode && cfgOut[0] ##1 sleepMode && cfgOut[0] |-> oscEnable)
    else $error("oscillator off in sleep with keep-on");
  a_sleep_off: assert property (sleepMode && !cfgOut[0] ##1 sleepMode && !cfgOut[0] |-> !oscEnable)
    else $error("oscillator on in sleep without keep-on");
endmodule : ostc_chk
bind ostc_ctrl ostc_chk u_chk (.*);

// [test/tb_top.sv]
// Purpose: self-checking bench for ostc_ctrl
// Assumes: zero-wait APB slave
// Notes: select code 3 skipped, run would be too long
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, oscRequest = 0, sleepMode = 0;
  logic [7:0]  paddr = 0, cfgOut;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, oscEnable, chipReadyLow, oscSettledFlag, irq, er;
  int          fails = 0, check_count = 0, seed = 32'he943fb95, d, n;
  always #2 clk = ~clk;
  ostc_ctrl u_dut (.*);
  //////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task complete_run;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    apb(0, 8'h18, 0);
    chk("cfg", rd, 32'h4);
    apb(0, 8'h20, 0);
    chk("errdata", rd, 0);
    chk("err", {31'h0, er}, 1);
    d = $random(seed);
    apb(1, 8'h18, d);
    apb(0, 8'h18, 0);
    chk("cfg", rd, d & 32'h3f);
    chk("cfgout", {24'h0, cfgOut}, d & 32'h3f);
    apb(1, 8'h44, 3);
    for (int s = 0; s < 3; s++) begin
      apb(1, 8'h18, s << 2);
      oscRequest <= 0;
      repeat (4) @(posedge clk);
      chk("rdyoff", chipReadyLow, 1);
      oscRequest <= 1;
      d = 0;
      while (chipReadyLow !== 1'b0 && d < 40000) begin
        @(posedge clk);
        d++;
      end
      n = 575 * (s == 0 ? 1 : s == 1 ? 16 : 64);
      chk("delay", d >= n && d <= n + 5, 1);
      chk("flag", {oscSettledFlag, irq}, 3);
      apb(0, 8'h40, 0);
      chk("stat", rd, s ? 3 : 1);
      apb(0, 8'h40, 0);
      chk("clr", rd, 0);
    end
    apb(1, 8'h44, 0);
    apb(1, 8'h18, 0);
    sleepMode <= 1;
    repeat (4) @(posedge clk);
    chk("sleep", {oscEnable, chipReadyLow, irq}, 3'h2);
    apb(0, 8'h40, 0);
    chk("stat", rd, 2);
    apb(1, 8'h18, 32'h9);
    repeat (4) @(posedge clk);
    chk("keep", oscEnable, 1);
    apb(0, 8'h48, 0);
    chk("sts", rd, 2);
    complete_run;
  end
endmodule : tb_top
